/* File: rtl/cdrv_pkg.sv */
// Package for the codec output driver control register bank.
// Assumes an 8-bit register port with a 7-bit register address on the core clock.
package cdrv_pkg;

    // Register addresses.
    localparam logic [6:0] CDRV_ADDR_DAC_PWR   = 7'h25;
    localparam logic [6:0] CDRV_ADDR_HP_CTRL   = 7'h26;
    localparam logic [6:0] CDRV_ADDR_RSVD      = 7'h27;
    localparam logic [6:0] CDRV_ADDR_OUT_STAGE = 7'h28;
    localparam logic [6:0] CDRV_ADDR_DAC_SW    = 7'h29;

    // Writable bit masks; all other bits are reserved and read as zero.
    localparam logic [7:0] CDRV_MASK_DAC_PWR   = 8'hf0;
    localparam logic [7:0] CDRV_MASK_HP_CTRL   = 8'h3e;
    localparam logic [7:0] CDRV_MASK_OUT_STAGE = 8'hff;
    localparam logic [7:0] CDRV_MASK_DAC_SW    = 8'hf3;

    // Reset values.
    localparam logic [7:0] CDRV_RST_REG        = 8'h00;

    // Field positions.
    localparam int CDRV_POS_LDAC_PWR  = 7;
    localparam int CDRV_POS_RDAC_PWR  = 6;
    localparam int CDRV_POS_LCOM      = 4;
    localparam int CDRV_POS_RCOM      = 3;
    localparam int CDRV_POS_SC_EN     = 2;
    localparam int CDRV_POS_SC_MODE   = 1;
    localparam int CDRV_POS_CM        = 6;
    localparam int CDRV_POS_LBYP      = 4;
    localparam int CDRV_POS_RBYP      = 2;
    localparam int CDRV_POS_SOFT      = 0;
    localparam int CDRV_POS_LSW       = 6;
    localparam int CDRV_POS_RSW       = 4;
    localparam int CDRV_POS_COUPLE    = 0;

    // Volume coupling codes.
    localparam logic [1:0] CDRV_COUPLE_L_FOLLOWS_R = 2'h1;
    localparam logic [1:0] CDRV_COUPLE_R_FOLLOWS_L = 2'h2;

    // Decoded driver settings handed to the analog side.
    typedef struct packed {
        logic       left_dac_pwr;
        logic       right_dac_pwr;
        logic [1:0] left_phones_complement_cfg;
        logic [2:0] right_phones_complement_cfg;
        logic       short_prot_en;
        logic       short_prot_pwrdn;
        logic [1:0] common_mode_level_sel;
        logic [1:0] left_second_line_bypass;
        logic [1:0] right_second_line_bypass;
        logic [1:0] soft_step_sel;
        logic [1:0] left_path_sel;
        logic [1:0] right_path_sel;
    } cdrv_cfg_t;

    // Register port request.
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [6:0] addr;
        logic [7:0] wdata;
    } cdrv_req_t;

endpackage : cdrv_pkg

/* File: rtl/cdrv_regs.sv */
// Output driver control register bank of the stereo codec.
// Assumes the control-bus bridge delivers one-cycle read and write strobes
// on mclk_in, and that the DAC volume registers live outside this block.
//
// Contract
// - Bit 7 of DAC power register powers up left DAC; resets zero.
// - Bit 6 of DAC power register powers up right DAC; resets zero.
// - Two-bit left complement driver config; code 11 reserved.
// - Three-bit right complement driver config, codes 000 to 100.
// - Bit 2 of high-power register enables short protection on all drivers.
// - Bit 1 picks current limit (0) or auto power-down (1).
// - Top two output stage bits select common-mode 1.35 to 1.8 V.
// - Left second-line bypass: off, positive, negative, differential.
// - Right second-line bypass uses the same encoding as left.
// - Soft-stepping: per sample, per two samples, off; 11 reserved.
// - Left DAC path switch: general, line, power driver; 11 reserved.
// - Right DAC path switch: general, line, power driver; 11 reserved.
// - Coupling 01 left follows right volume, 10 right follows left.
// - Coupling code 11 behaves exactly like 00, independent volume.
// - DAC volume is seven-bit half-decibel attenuation, zero means 0 dB.
`timescale 1ns/1ps
`default_nettype none

module cdrv_regs
    import cdrv_pkg::*;
(
    input  wire logic       mclk_in,
    input  wire logic       resetn_in,
    input  wire cdrv_req_t  req_in,
    input  wire logic [6:0] left_vol_reg_in,
    input  wire logic [6:0] right_vol_reg_in,
    output var  logic [7:0] rdata_out,
    output var  logic       rvalid_out,
    output var  cdrv_cfg_t  cfg_out,
    output var  logic [6:0] left_vol_eff_out,
    output var  logic [6:0] right_vol_eff_out
);

    // Register images. Reserved bits of every image are held at zero.
    logic [7:0] dac_power_driver_config_r;
    logic [7:0] dac_power_driver_config_nxt;
    logic [7:0] high_power_driver_control_r;
    logic [7:0] high_power_driver_control_nxt;
    logic [7:0] output_stage_control_r;
    logic [7:0] output_stage_control_nxt;
    logic [7:0] dac_output_switching_r;
    logic [7:0] dac_output_switching_nxt;

    // Next values of the output flops.
    logic [7:0] rdata_nxt;
    logic       rvalid_nxt;
    cdrv_cfg_t  cfg_nxt;
    logic [6:0] left_vol_nxt;
    logic [6:0] right_vol_nxt;
    logic [1:0] couple;

    // One write select per stored register.
    logic       wr_dac_pwr;
    logic       wr_hp_ctrl;
    logic       wr_out_stage;
    logic       wr_dac_sw;

    // One read select per readable register.
    logic       rd_dac_pwr;
    logic       rd_hp_ctrl;
    logic       rd_out_stage;
    logic       rd_dac_sw;

    // Coupling selects decoded from the switching register.
    logic       left_from_right;
    logic       right_from_left;

    // Write address decode. The reserved slot and all unmapped addresses
    // select no register, so a stray write there cannot disturb any state.
    // A read in the same cycle is not affected: it sees the old contents.
    always_comb begin
        wr_dac_pwr   = 1'b0;
        wr_hp_ctrl   = 1'b0;
        wr_out_stage = 1'b0;
        wr_dac_sw    = 1'b0;
        if (req_in.wr) begin
            case (req_in.addr)
                CDRV_ADDR_DAC_PWR: begin
                    wr_dac_pwr = 1'b1;
                end
                CDRV_ADDR_HP_CTRL: begin
                    wr_hp_ctrl = 1'b1;
                end
                CDRV_ADDR_OUT_STAGE: begin
                    wr_out_stage = 1'b1;
                end
                CDRV_ADDR_DAC_SW: begin
                    wr_dac_sw = 1'b1;
                end
                default: begin
                    // Reserved slot and unmapped addresses select nothing.
                    wr_dac_sw = 1'b0;
                end
            endcase
        end
    end

    // DAC power and left complement driver register.
    // Bit 7 powers the left DAC channel and bit 6 the right one; both come
    // up cleared, so the converters stay off until software asks for them.
    // Bits 5:4 set the left complement driver: 00 inverse of the left main
    // driver, 01 steady common-mode level, 10 independent single-ended.
    // Code 11 is not to be written; it is kept as written and passed on.
    // The low nibble is reserved and is dropped on write, so that a
    // read-modify-write by software never carries junk back into it.
    always_comb begin
        dac_power_driver_config_nxt = dac_power_driver_config_r;
        if (wr_dac_pwr) begin
            dac_power_driver_config_nxt = req_in.wdata & CDRV_MASK_DAC_PWR;
        end
    end

    // Storage of the DAC power register, cleared by reset.
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            dac_power_driver_config_r <= CDRV_RST_REG;
        end else begin
            dac_power_driver_config_r <= dac_power_driver_config_nxt;
        end
    end

    // High-power driver control register.
    // Bits 5:3 set the right complement driver: 000 inverse of the right
    // main driver, 001 steady common-mode level, 010 single-ended, 011
    // inverse of the left complement driver, 100 external feedback with
    // the left complement driver parked at common mode.
    // Bit 2 turns on short protection for every high-power driver and
    // bit 1 chooses between current limiting and automatic power-down.
    // Bits 7:6 and bit 0 are reserved and are dropped on write.
    always_comb begin
        high_power_driver_control_nxt = high_power_driver_control_r;
        if (wr_hp_ctrl) begin
            high_power_driver_control_nxt = req_in.wdata & CDRV_MASK_HP_CTRL;
        end
    end

    // Storage of the high-power driver register, cleared by reset.
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            high_power_driver_control_r <= CDRV_RST_REG;
        end else begin
            high_power_driver_control_r <= high_power_driver_control_nxt;
        end
    end

    // Output stage register; all eight bits are writable.
    // Bits 7:6 pick the output common-mode level, 1.35 V at 00 rising in
    // steps to 1.8 V at 11. Bits 5:4 and 3:2 route the left and right
    // second line inputs around the converters: 00 off, 01 positive input,
    // 10 negative input, 11 both inputs differentially.
    // Bits 1:0 set the volume soft-stepping rate: 00 one step per sample,
    // 01 one step per two samples, 10 no stepping; 11 is not to be written.
    always_comb begin
        output_stage_control_nxt = output_stage_control_r;
        if (wr_out_stage) begin
            output_stage_control_nxt = req_in.wdata & CDRV_MASK_OUT_STAGE;
        end
    end

    // Storage of the output stage register, cleared by reset.
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            output_stage_control_r <= CDRV_RST_REG;
        end else begin
            output_stage_control_r <= output_stage_control_nxt;
        end
    end

    // DAC output switching register.
    // Bits 7:6 and 5:4 steer the left and right DAC outputs: 00 general
    // path, 01 line driver path, 10 high-power driver path; 11 is not to be
    // written. Bits 1:0 couple the digital volumes of the two channels.
    // Bits 3:2 are reserved and are dropped on write.
    always_comb begin
        dac_output_switching_nxt = dac_output_switching_r;
        if (wr_dac_sw) begin
            dac_output_switching_nxt = req_in.wdata & CDRV_MASK_DAC_SW;
        end
    end

    // Storage of the DAC output switching register, cleared by reset.
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            dac_output_switching_r <= CDRV_RST_REG;
        end else begin
            dac_output_switching_r <= dac_output_switching_nxt;
        end
    end

    // Read address decode, one select per readable image.
    // The reserved slot has no select of its own: like every unmapped
    // address it falls through to zero, which is what software expects
    // to see there after reset and at any later time.
    always_comb begin
        rd_dac_pwr   = 1'b0;
        rd_hp_ctrl   = 1'b0;
        rd_out_stage = 1'b0;
        rd_dac_sw    = 1'b0;
        if (req_in.rd) begin
            case (req_in.addr)
                CDRV_ADDR_DAC_PWR: begin
                    rd_dac_pwr = 1'b1;
                end
                CDRV_ADDR_HP_CTRL: begin
                    rd_hp_ctrl = 1'b1;
                end
                CDRV_ADDR_OUT_STAGE: begin
                    rd_out_stage = 1'b1;
                end
                CDRV_ADDR_DAC_SW: begin
                    rd_dac_sw = 1'b1;
                end
                default: begin
                    // Reserved slot and unmapped addresses read as zero.
                    rd_dac_sw = 1'b0;
                end
            endcase
        end
    end

    // Read data mux. Every read is answered one cycle later, whatever the
    // address; the data are zero unless a mapped image was selected, and
    // zero again on every cycle without a read, so no answer lingers.
    always_comb begin
        rvalid_nxt = req_in.rd;
        rdata_nxt  = CDRV_RST_REG;
        if (rd_dac_pwr) begin
            rdata_nxt = dac_power_driver_config_r;
        end
        if (rd_hp_ctrl) begin
            rdata_nxt = high_power_driver_control_r;
        end
        if (rd_out_stage) begin
            rdata_nxt = output_stage_control_r;
        end
        if (rd_dac_sw) begin
            rdata_nxt = dac_output_switching_r;
        end
    end

    // Field decode toward the analog drivers.
    // Each field but short_prot_pwrdn is copied out of its register image unchanged, reserved
    // codes included: the analog side is told exactly what software
    // wrote, and no code is silently swapped for another one.
    // The power-down mode of the short protection only counts while the
    // protection itself is on, so that flag is gated by the enable bit;
    // with protection off the drivers neither limit nor shut down.
    // All fields pass through the output flops below, so the analog side
    // never sees a half-written register between two clock edges.
    // The register images only change on a write, so these stay put.
    always_comb begin
        cfg_nxt.left_dac_pwr                = dac_power_driver_config_r[CDRV_POS_LDAC_PWR];
        cfg_nxt.right_dac_pwr               = dac_power_driver_config_r[CDRV_POS_RDAC_PWR];
        cfg_nxt.left_phones_complement_cfg  = dac_power_driver_config_r[CDRV_POS_LCOM +: 2];
        cfg_nxt.right_phones_complement_cfg = high_power_driver_control_r[CDRV_POS_RCOM +: 3];
        cfg_nxt.short_prot_en               = high_power_driver_control_r[CDRV_POS_SC_EN];
        // Mode only matters while protection is on.
        cfg_nxt.short_prot_pwrdn            = high_power_driver_control_r[CDRV_POS_SC_EN]
                                              & high_power_driver_control_r[CDRV_POS_SC_MODE];
        cfg_nxt.common_mode_level_sel       = output_stage_control_r[CDRV_POS_CM +: 2];
        cfg_nxt.left_second_line_bypass     = output_stage_control_r[CDRV_POS_LBYP +: 2];
        cfg_nxt.right_second_line_bypass    = output_stage_control_r[CDRV_POS_RBYP +: 2];
        cfg_nxt.soft_step_sel               = output_stage_control_r[CDRV_POS_SOFT +: 2];
        cfg_nxt.left_path_sel               = dac_output_switching_r[CDRV_POS_LSW +: 2];
        cfg_nxt.right_path_sel              = dac_output_switching_r[CDRV_POS_RSW +: 2];
    end

    // Volume coupling. The outside left and right volume registers each
    // hold a seven-bit attenuation in half-decibel steps, zero meaning
    // no attenuation. Code 01 in the coupling field makes the left
    // channel use the right register, code 10 the right channel the left
    // register; 00 and 11 keep the channels independent. The values are
    // passed through untouched, so the attenuation scale is preserved.
    // The coupling code is read from the stored register, not from the
    // request, so a write takes effect one cycle after it is accepted,
    // in step with the decoded fields. A volume change on the inputs
    // shows up after one cycle as well.
    assign couple = dac_output_switching_r[CDRV_POS_COUPLE +: 2];

    // Coupling code decode; 00 and 11 leave both selects low.
    always_comb begin
        left_from_right = 1'b0;
        right_from_left = 1'b0;
        case (couple)
            CDRV_COUPLE_L_FOLLOWS_R: begin
                left_from_right = 1'b1;
            end
            CDRV_COUPLE_R_FOLLOWS_L: begin
                right_from_left = 1'b1;
            end
            default: begin
                // Codes 00 and 11: the channels keep their own volumes.
                left_from_right = 1'b0;
            end
        endcase
    end

    // Volume source selection.
    always_comb begin
        left_vol_nxt  = left_vol_reg_in;
        right_vol_nxt = right_vol_reg_in;
        if (left_from_right) begin
            left_vol_nxt = right_vol_reg_in;
        end
        if (right_from_left) begin
            right_vol_nxt = left_vol_reg_in;
        end
    end

    // Read answer flops. rvalid_out is a one-cycle pulse and rdata_out
    // is zero outside it, so a stale answer can never be taken twice.
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rdata_out  <= CDRV_RST_REG;
            rvalid_out <= 1'b0;
        end else begin
            rdata_out  <= rdata_nxt;
            rvalid_out <= rvalid_nxt;
        end
    end

    // Decoded field flops. The analog side sees a write one cycle after
    // the register takes it, and every field is zero straight out of
    // reset, which leaves both DAC channels powered down.
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cfg_out <= '0;
        end else begin
            cfg_out <= cfg_nxt;
        end
    end

    // Effective volume flops. They follow the outside volume registers
    // with one cycle of delay, after the coupling choice has been applied;
    // zero out of reset means no attenuation until the inputs are seen.
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            left_vol_eff_out  <= 7'h00;
            right_vol_eff_out <= 7'h00;
        end else begin
            left_vol_eff_out  <= left_vol_nxt;
            right_vol_eff_out <= right_vol_nxt;
        end
    end

endmodule : cdrv_regs
`default_nettype wire

/* File: verif/cdrv_regs_monitor.sv */
// Checker for the output driver control register bank.
// Assumes one-cycle strobes on mclk_in; bound to every cdrv_regs instance.
`timescale 1ns/1ps
`default_nettype none
module cdrv_regs_monitor
    import cdrv_pkg::*;
(
    input  wire logic       mclk_in,
    input  wire logic       resetn_in,
    input  wire cdrv_req_t  req_in,
    input  wire logic [6:0] left_vol_reg_in,
    input  wire logic [6:0] right_vol_reg_in,
    input  wire logic [7:0] rdata_out,
    input  wire logic       rvalid_out,
    input  wire cdrv_cfg_t  cfg_out,
    input  wire logic [6:0] left_vol_eff_out,
    input  wire logic [6:0] right_vol_eff_out
);
    // Everything runs on the core clock and is paused while reset is held.
    default clocking dcb @(posedge mclk_in); endclocking
    default disable iff (!resetn_in);
    // A write to one address, and a coupling write left alone for one cycle.
    sequence s_wr(logic [6:0] a);
        req_in.wr && req_in.addr == a;
    endsequence
    sequence s_cpl(logic [1:0] c);
        req_in.wr && req_in.addr == CDRV_ADDR_DAC_SW && req_in.wdata[1:0] == c ##1 !req_in.wr;
    endsequence
    chk_read_answer: assert property (req_in.rd |=> rvalid_out)
        else $error("read strobe got no answer");
    chk_idle_zero: assert property (!rvalid_out |-> rdata_out == 8'h00)
        else $error("read data not zero while idle");
    chk_rsvd_zero: assert property (req_in.rd && req_in.addr == CDRV_ADDR_RSVD |=> rdata_out == 8'h00)
        else $error("reserved register read not zero");
    chk_hp_bits: assert property (req_in.rd && req_in.addr == CDRV_ADDR_HP_CTRL |=> (rdata_out & 8'hc1) == 8'h00)
        else $error("reserved driver bits read not zero");
    chk_dac_power: assert property (s_wr(CDRV_ADDR_DAC_PWR) |=> ##1 {cfg_out.left_dac_pwr, cfg_out.right_dac_pwr} == $past(req_in.wdata[7:6], 2))
        else $error("channel power does not follow write");
    chk_stage_decode: assert property (s_wr(CDRV_ADDR_OUT_STAGE) |=> ##1 {cfg_out.common_mode_level_sel, cfg_out.left_second_line_bypass, cfg_out.right_second_line_bypass, cfg_out.soft_step_sel} == $past(req_in.wdata, 2))
        else $error("output stage fields do not follow write");
    chk_path_decode: assert property (s_wr(CDRV_ADDR_DAC_SW) |=> ##1 {cfg_out.left_path_sel, cfg_out.right_path_sel} == $past(req_in.wdata[7:4], 2))
        else $error("path select does not follow write");
    chk_prot_mode: assert property (cfg_out.short_prot_pwrdn |-> cfg_out.short_prot_en)
        else $error("auto power-down without protection");
    chk_l_follows_r: assert property (s_cpl(2'h1) |=> left_vol_eff_out == $past(right_vol_reg_in))
        else $error("left volume does not follow right");
    chk_r_follows_l: assert property (s_cpl(2'h2) |=> right_vol_eff_out == $past(left_vol_reg_in))
        else $error("right volume does not follow left");
endmodule : cdrv_regs_monitor
bind cdrv_regs cdrv_regs_monitor u_cdrv_regs_monitor (.mclk_in(mclk_in), .resetn_in(resetn_in), .req_in(req_in),
    .left_vol_reg_in(left_vol_reg_in), .right_vol_reg_in(right_vol_reg_in), .rdata_out(rdata_out),
    .rvalid_out(rvalid_out), .cfg_out(cfg_out), .left_vol_eff_out(left_vol_eff_out),
    .right_vol_eff_out(right_vol_eff_out));
`default_nettype wire

/* File: verif/cdrv_regs_tb.sv */
// Self-checking bench for the output driver control register bank.
// Assumes the register port contract of cdrv_regs; inputs move on falling edges.
`timescale 1ns/1ps
`default_nettype none
module cdrv_regs_tb import cdrv_pkg::*; ;
    logic       mclk_in   = 1'b0;
    logic       resetn_in = 1'b0;
    cdrv_req_t  req_in    = '0;
    logic [6:0] lv        = 7'h11;
    logic [6:0] rv        = 7'h6a;
    logic [7:0] rdata_out;
    logic       rvalid_out;
    cdrv_cfg_t  cfg_out;
    logic [6:0] lve;
    logic [6:0] rve;
    int         n_fail    = 0;
    int         checks    = 0;
    int         i;
    logic [7:0] d;
    // The 200 MHz core clock.
    always #2.5 mclk_in = ~mclk_in;
    cdrv_regs u_cdrv_regs (.mclk_in(mclk_in), .resetn_in(resetn_in), .req_in(req_in), .left_vol_reg_in(lv),
        .right_vol_reg_in(rv), .rdata_out(rdata_out), .rvalid_out(rvalid_out), .cfg_out(cfg_out),
        .left_vol_eff_out(lve), .right_vol_eff_out(rve));
    // Compares one result and counts it.
    task automatic chk(string nm, logic [20:0] exp, logic [20:0] got);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // One write strobe, then one cycle for the decoded outputs to follow.
    task automatic wr(logic [6:0] a, logic [7:0] v);
        @(negedge mclk_in);
        req_in = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
        @(negedge mclk_in);
        req_in = '0;
        @(negedge mclk_in);
    endtask : wr
    // One read strobe; waits a bounded time for the answer and compares it.
    task automatic rd(logic [6:0] a, logic [7:0] exp);
        int k;
        @(negedge mclk_in);
        req_in = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge mclk_in);
        req_in = '0;
        for (k = 0; k < 4 && rvalid_out !== 1'b1; k++) @(negedge mclk_in);
        chk("rvalid", 21'h1, 21'(rvalid_out));
        chk("rdata", 21'(exp), 21'(rdata_out));
    endtask : rd
    // Prints the counts and the verdict, then ends the run.
    task automatic test_done();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : test_done
    // Cuts a hang short.
    initial begin
        #20000;
        n_fail++;
        test_done();
    end
    // Main sequence of register accesses.
    initial begin
        repeat (20) @(negedge mclk_in);
        resetn_in = 1'b1;
        chk("cfg", 21'h0, cfg_out);
        for (i = 0; i < 6; i++) rd(7'(CDRV_ADDR_DAC_PWR + i), 8'h00);
        for (i = 0; i < 3; i++) begin
            wr(CDRV_ADDR_DAC_PWR, 8'hcf | 8'(i << 4));
            rd(CDRV_ADDR_DAC_PWR, 8'hc0 | 8'(i << 4));
            chk("lcom", 21'(i), 21'(cfg_out.left_phones_complement_cfg));
        end
        wr(CDRV_ADDR_DAC_PWR, 8'h80);
        chk("pwr", 21'h2, 21'({cfg_out.left_dac_pwr, cfg_out.right_dac_pwr}));
        for (i = 0; i < 5; i++) begin
            d = 8'(i << 3) | 8'h04 | 8'((i & 1) << 1);
            wr(CDRV_ADDR_HP_CTRL, d | 8'hc0);
            rd(CDRV_ADDR_HP_CTRL, d);
            chk("rcom", 21'(i), 21'(cfg_out.right_phones_complement_cfg));
            chk("prot", 21'(2 | (i & 1)), 21'({cfg_out.short_prot_en, cfg_out.short_prot_pwrdn}));
        end
        wr(CDRV_ADDR_HP_CTRL, 8'h02);
        chk("prot", 21'h0, 21'({cfg_out.short_prot_en, cfg_out.short_prot_pwrdn}));
        for (i = 0; i < 4; i++) begin
            d = 8'(i * 8'h54) | 8'(i % 3);
            wr(CDRV_ADDR_OUT_STAGE, d);
            rd(CDRV_ADDR_OUT_STAGE, d);
            chk("stage", 21'(d), 21'({cfg_out.common_mode_level_sel, cfg_out.left_second_line_bypass,
                cfg_out.right_second_line_bypass, cfg_out.soft_step_sel}));
        end
        for (i = 0; i < 4; i++) begin
            lv = 7'(8'h11 + i);
            d = 8'((i % 3) * 8'h50) | 8'h0c | 8'(i);
            wr(CDRV_ADDR_DAC_SW, d);
            rd(CDRV_ADDR_DAC_SW, d & 8'hf3);
            chk("path", 21'((i % 3) * 5), 21'({cfg_out.left_path_sel, cfg_out.right_path_sel}));
            chk("lvol", 21'(i == 1 ? rv : lv), 21'(lve));
            chk("rvol", 21'(i == 2 ? lv : rv), 21'(rve));
        end
        wr(7'h2a, 8'hff);
        wr(7'h30, 8'hff);
        rd(CDRV_ADDR_RSVD, 8'h00);
        rd(7'h30, 8'h00);
        rd(CDRV_ADDR_DAC_SW, 8'h03);
        test_done();
    end
endmodule : cdrv_regs_tb
`default_nettype wire
